/* File: rcs_clock_select.sv */
// receive clock source selector with apb registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defs.svh"
module rcs_clock_select (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // pins from the outside world
    input wire logic i_detector_gate_enable,
    input wire logic i_force_local_ref_n,
    input wire logic i_rx_clock_rate_sel,
    input wire logic i_level_ok,
    input wire logic i_range_ok,
    input wire logic i_training_ref_present,
    input wire logic i_rx_bit,
    input wire logic i_bit_toggle,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // clock and status outputs
    output logic o_rx_parallel_clock,
    output logic o_reclocker_clock_out,
    output rcs_pkg::rcs_src_t o_rx_recovery_pll_src,
    output logic o_link_fault_n,
    output logic [1:0] o_signal_level_trip_sel,
    output logic o_irq
);
    import rcs_pkg::*;

    localparam int NPIN = 8;
    // pin vector, all asynchronous to i_clk_sys
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1; // first stage, read only by pin_s2
    logic [NPIN-1:0] pin_s2; // usable synchronised level
    logic toggle_d; // previous synchronised bit toggle
    logic bit_tick; // one pulse per recovered serial bit
    logic gate, force_n, rate_sel, level_ok, range_ok, ref_ok, rx_bit;
    logic prev_bit; // last recovered bit value
    logic [5:0] run_len; // identical bits in a row
    logic density_ok;
    logic [3:0] bit_cnt; // bit position inside a character
    logic half_sel; // alternates each character
    logic [2:0] ctrl; // trip select and channel enable
    logic chan_en;
    logic [2:0] int_stat;
    logic [2:0] int_en;
    rcs_apb_t apb_st;
    logic acc_done; // access completes this edge
    logic use_ref; // combinational lock source decision
    logic fault; // combinational link fault
    logic [2:0] events;
    logic [2:0] clr_mask;

    assign pin_raw = {i_bit_toggle, i_rx_bit, i_training_ref_present, i_range_ok,
                      i_level_ok, i_rx_clock_rate_sel, i_force_local_ref_n, i_detector_gate_enable};

    // two flip-flop synchroniser per pin
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    pin_s1[g] <= 1'b0;
                    pin_s2[g] <= 1'b0;
                end else begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                end
            end
        end
    endgenerate

    assign gate = pin_s2[0];
    assign force_n = pin_s2[1];
    assign rate_sel = pin_s2[2];
    assign level_ok = pin_s2[3];
    assign range_ok = pin_s2[4];
    assign ref_ok = pin_s2[5];
    assign rx_bit = pin_s2[6];
    assign bit_tick = pin_s2[7] ^ toggle_d;
    assign chan_en = ctrl[`RCS_CTRL_CHAN_EN_BIT];

    // bit edge detect on the settled stage only
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            toggle_d <= 1'b0;
        end else begin
            toggle_d <= pin_s2[7];
        end
    end

    // transition density: run of identical bits
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            prev_bit <= 1'b0;
            run_len <= 6'h01;
        end else if (bit_tick) begin
            prev_bit <= rx_bit;
            if (rx_bit != prev_bit) begin
                run_len <= 6'h01; // a transition restarts the window
            end else if (run_len != `RCS_DENSITY_LIMIT) begin
                run_len <= run_len + 6'h01; // saturates at the limit
            end
        end
    end
    // 60 identical bits hold no transition
    assign density_ok = (run_len != `RCS_DENSITY_LIMIT);

    // lock source decision, re-evaluated every cycle
    always_comb begin
        if (!force_n) begin
            use_ref = 1'b1;
        end else if (gate) begin
            use_ref = !level_ok || !range_ok || !density_ok;
        end else begin
            use_ref = !range_ok;
        end
    end

    // link fault is the or of six conditions
    assign fault = !range_ok || !level_ok || !density_ok || !chan_en || !force_n || !ref_ok;

    // source and fault outputs registered, no latching so removal recovers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rx_recovery_pll_src <= RCS_SRC_REF;
            o_link_fault_n <= 1'b0;
        end else begin
            o_rx_recovery_pll_src <= use_ref ? RCS_SRC_REF : RCS_SRC_DATA;
            o_link_fault_n <= !fault;
        end
    end

    // character clock from recovered bit ticks only
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            bit_cnt <= 4'h0;
            half_sel <= 1'b0;
        end else if (bit_tick) begin
            if (bit_cnt == `RCS_BITS_PER_CHAR - 4'h1) begin
                bit_cnt <= 4'h0;
                half_sel <= !half_sel;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // parallel clock: rate 1 half character rate, rate 0 character rate
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_rx_parallel_clock <= 1'b0;
        end else if (rate_sel) begin
            o_rx_parallel_clock <= half_sel; // twenty bits per period
        end else begin
            o_rx_parallel_clock <= (bit_cnt < `RCS_HALF_CHAR_BITS); // ten bits per period
        end
    end

    // reclocker runs at character rate, same or twice the parallel clock
    // phase against the parallel clock is fixed, the inverse of it at rate 0
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_reclocker_clock_out <= 1'b0;
        end else begin
            o_reclocker_clock_out <= (bit_cnt >= `RCS_HALF_CHAR_BITS);
        end
    end

    // apb phase: ready one cycle into the access phase
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            apb_st <= RCS_IDLE;
        end else begin
            unique case (apb_st)
                RCS_IDLE: begin
                    if (i_psel && i_penable) begin
                        apb_st <= RCS_ACCESS;
                    end
                end
                RCS_ACCESS: begin
                    apb_st <= RCS_DONE;
                end
                RCS_DONE: begin
                    apb_st <= RCS_IDLE;
                end
                default: begin // fourth code is unused, fall back to idle
                    apb_st <= RCS_IDLE;
                end
            endcase
        end
    end
    assign acc_done = o_pready && i_psel && i_penable;

    // ready, error and read data registered
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else if (apb_st == RCS_IDLE && i_psel && i_penable) begin
            o_pready <= 1'b1;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
            case (i_paddr)
                `RCS_CTRL_OFS: o_prdata <= {29'h0, ctrl};
                `RCS_STATUS_OFS: o_prdata <= {24'h0, !fault, density_ok, range_ok, level_ok,
                                             rate_sel, gate, force_n, !use_ref};
                `RCS_INT_STAT_OFS: o_prdata <= {29'h0, int_stat};
                `RCS_INT_EN_OFS: o_prdata <= {29'h0, int_en};
                `RCS_INT_CLR_OFS: o_prdata <= 32'h0; // write only
                default: o_pslverr <= 1'b1; // unmapped address
            endcase
        end else begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // control and interrupt enable registers, writes take effect at the completing edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ctrl <= `RCS_CTRL_RST;
            int_en <= `RCS_INT_EN_RST;
        end else if (acc_done && i_pwrite) begin
            if (i_paddr == `RCS_CTRL_OFS) begin
                ctrl <= i_pwdata[2:0];
            end
            if (i_paddr == `RCS_INT_EN_OFS) begin
                int_en <= i_pwdata[2:0];
            end
        end
    end

    // trip threshold goes straight to the analog level detector
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_signal_level_trip_sel <= 2'h0;
        end else begin
            o_signal_level_trip_sel <= ctrl[`RCS_CTRL_TRIP_LSB +: 2];
        end
    end

    // events: source changes and density loss
    assign events[`RCS_EV_TO_REF] = use_ref && (o_rx_recovery_pll_src == RCS_SRC_DATA);
    assign events[`RCS_EV_TO_DATA] = !use_ref && (o_rx_recovery_pll_src == RCS_SRC_REF);
    assign events[`RCS_EV_DENSITY] = bit_tick && rx_bit == prev_bit
                                     && run_len == `RCS_DENSITY_LIMIT - 6'h01;
    assign clr_mask = (acc_done && i_pwrite && i_paddr == `RCS_INT_CLR_OFS) ? i_pwdata[2:0] : 3'h0;

    // sticky status, a new event beats a clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            int_stat <= 3'h0;
        end else begin
            int_stat <= (int_stat & ~clr_mask) | events;
        end
    end

    // level interrupt
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((int_stat & ~clr_mask) | events) & int_en);
        end
    end

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    property p_force_ref;
        !force_n |=> o_rx_recovery_pll_src == RCS_SRC_REF;
    endproperty
    a_force_ref: assert property (p_force_ref) else $error("force-local low not on reference");

    property p_force_fault;
        !force_n |=> !o_link_fault_n;
    endproperty
    a_force_fault: assert property (p_force_fault) else $error("force-local low without link fault");

    property p_gate_detect;
        force_n && gate && !level_ok |=> o_rx_recovery_pll_src == RCS_SRC_REF;
    endproperty
    a_gate_detect: assert property (p_gate_detect) else $error("level fault ignored with gate high");

    property p_gate_low;
        force_n && !gate && range_ok |=> o_rx_recovery_pll_src == RCS_SRC_DATA;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gate low uses more than range");

    property p_all_ok;
        force_n && gate && level_ok && range_ok && density_ok |=> o_rx_recovery_pll_src == RCS_SRC_DATA;
    endproperty
    a_all_ok: assert property (p_all_ok) else $error("not back on data with all valid");

    property p_density;
        bit_tick && rx_bit != prev_bit |=> density_ok;
    endproperty
    a_density: assert property (p_density) else $error("transition did not clear density fault");

    property p_rate_half;
        // rate must hold across the toggle, a rate change may legally skip it
        rate_sel && bit_tick && bit_cnt == `RCS_BITS_PER_CHAR - 4'h1 ##1 rate_sel
            |=> o_rx_parallel_clock != $past(o_rx_parallel_clock);
    endproperty
    a_rate_half: assert property (p_rate_half) else $error("half rate clock missed toggle");

    property p_reclk;
        bit_tick && bit_cnt == `RCS_HALF_CHAR_BITS - 4'h1 |=> ##1 o_reclocker_clock_out;
    endproperty
    a_reclk: assert property (p_reclk) else $error("reclocker clock not high mid character");

    property p_ref_fault;
        !ref_ok |=> !o_link_fault_n;
    endproperty
    a_ref_fault: assert property (p_ref_fault) else $error("missing reference not a link fault");

endmodule // rcs_clock_select
`default_nettype wire

/* File: rcs_clock_select_test.sv */
// self-checking bench for the receive clock source selector
`timescale 1ns/1ps
`default_nettype none
module rcs_clock_select_test;
    import rcs_pkg::*;
    logic clk, rstn, gate, force_n, rate, level_ok, range_ok, ref_ok, stuck, rx_bit, toggle;
    logic psel, penable, pwrite, pready, pslverr, par_clk, rec_clk, fault_n, irq, eb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] trip;
    rcs_src_t src;
    int err_count, num_checks;
    // block under test
    rcs_clock_select rcs_clock_select_inst (.i_clk_sys(clk), .i_rstn(rstn),
        .i_detector_gate_enable(gate), .i_force_local_ref_n(force_n), .i_rx_clock_rate_sel(rate),
        .i_level_ok(level_ok), .i_range_ok(range_ok), .i_training_ref_present(ref_ok),
        .i_rx_bit(rx_bit), .i_bit_toggle(toggle), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .o_rx_parallel_clock(par_clk),
        .o_reclocker_clock_out(rec_clk), .o_rx_recovery_pll_src(src), .o_link_fault_n(fault_n),
        .o_signal_level_trip_sel(trip), .o_irq(irq));
    // far side serial stream
    rcs_serial_source rcs_serial_source_inst (.i_clk_sys(clk), .i_stuck(stuck),
        .o_rx_bit(rx_bit), .o_bit_toggle(toggle));
    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // exact four-state compare
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, request held until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++; // slave never answered
                finish_test();
            end
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // register write, no error expected
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, eb);
        chk("write err", 32'h0, {31'h0, eb});
    endtask
    // register read against expected word
    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, eb);
        chk(name, exp, rd);
    endtask
    // pin changes reach outputs three edges later
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask
    // pll source and link fault together
    task automatic pins(input logic s, input logic f);
        chk("pll source", {31'h0, s}, {31'h0, src});
        chk("link fault", {31'h0, f}, {31'h0, fault_n});
    endtask
    // cycles between two rising edges of an output clock
    task automatic period(input string name, input logic which, input int exp);
        int n, t0;
        logic p, c;
        p = 1'b1;
        n = 0;
        t0 = -1;
        while (n < 400) begin
            @(posedge clk);
            c = which ? rec_clk : par_clk;
            if (c === 1'b1 && p === 1'b0) begin
                if (t0 >= 0) break;
                t0 = n;
            end
            p = c;
            n++;
        end
        if (n >= 400) begin
            err_count++; // clock stopped
            finish_test();
        end
        chk(name, exp, n - t0);
    endtask
    // main sequence
    initial begin
        rstn = 1'b0;
        gate = 1'b1; // all three detectors take part
        force_n = 1'b1;
        rate = 1'b0;
        level_ok = 1'b1;
        range_ok = 1'b1;
        ref_ok = 1'b1;
        stuck = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        pins(1'b0, 1'b0);
        rstn <= 1'b1;
        rdc("ctrl", 12'h000, 32'h4);
        rdc("int en", 12'h00c, 32'h0);
        rdc("int clr", 12'h010, 32'h0);
        apb(1'b0, 12'h020, 32'h0, rd, eb);
        chk("unmapped err", 32'h1, {31'h0, eb});
        settle();
        pins(1'b1, 1'b1);
        rdc("status", 12'h004, 32'hf7);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, 32'h4 | i);
            settle();
            chk("trip sel", i, {30'h0, trip});
        end
        wr(12'h000, 32'h0);
        settle();
        chk("fault chan off", 32'h0, {31'h0, fault_n});
        wr(12'h000, 32'h4);
        force_n <= 1'b0;
        settle();
        pins(1'b0, 1'b0);
        force_n <= 1'b1;
        settle();
        pins(1'b1, 1'b1);
        $display("test control done");
        // level, range, then training reference out, gate high then low
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 3; k++) begin
                gate <= (g == 0);
                level_ok <= (k != 0);
                range_ok <= (k != 1);
                ref_ok <= (k != 2);
                settle();
                if (k == 2) chk("fault no ref", 32'h0, {31'h0, fault_n});
                else pins(k == 0 && g == 1, 1'b0);
            end
        end
        gate <= 1'b1;
        level_ok <= 1'b1;
        range_ok <= 1'b1;
        ref_ok <= 1'b1;
        settle();
        pins(1'b1, 1'b1);
        $display("test detectors done");
        repeat (120) @(posedge clk);
        period("par clk full", 1'b0, 50);
        period("reclk full", 1'b1, 50);
        rate <= 1'b1;
        repeat (120) @(posedge clk);
        period("par clk half", 1'b0, 100);
        period("reclk half", 1'b1, 50);
        $display("test clocks done");
        // flat run longer than the density limit
        wr(12'h010, 32'h7);
        gate <= 1'b0;
        stuck <= 1'b1;
        repeat (400) @(posedge clk);
        pins(1'b1, 1'b0);
        rdc("int stat", 12'h008, 32'h4);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(12'h00c, 32'h4);
        repeat (3) @(posedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(12'h010, 32'h7);
        repeat (3) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        gate <= 1'b1;
        settle();
        pins(1'b0, 1'b0);
        rdc("int stat ref", 12'h008, 32'h1);
        stuck <= 1'b0;
        repeat (20) @(posedge clk);
        pins(1'b1, 1'b1);
        rdc("int stat data", 12'h008, 32'h3);
        $display("test density done");
        finish_test();
    end
endmodule // rcs_clock_select_test
`default_nettype wire

/* File: rcs_defs.svh */
// constants of the receive clock source selector
// Function
// - parallel clock at 1/20 or 1/10 bit rate
// - reclocker clock same or twice parallel clock
// - reclocker clock derived from recovered character clock
// - reset places all state in defined values
// - gate high enables all three detectors
// - any detector out, lock to training reference
// - no transition in 60 bits is violation
// - gate low uses only range controller
// - two-bit setting selects level trip threshold
// - force-local low locks to training reference
// - force-local low drives link fault low
// - force-local high recovers data subject detectors
// - parallel clock derived from recovered data alone
// - link fault on any of six conditions
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH
// register byte offsets
`define RCS_CTRL_OFS 12'h000
`define RCS_STATUS_OFS 12'h004
`define RCS_INT_STAT_OFS 12'h008
`define RCS_INT_EN_OFS 12'h00c
`define RCS_INT_CLR_OFS 12'h010
// control fields
`define RCS_CTRL_TRIP_LSB 0
`define RCS_CTRL_CHAN_EN_BIT 2
// reset values
`define RCS_CTRL_RST 3'h4
`define RCS_INT_EN_RST 3'h0
// interrupt bit positions
`define RCS_EV_TO_REF 0
`define RCS_EV_TO_DATA 1
`define RCS_EV_DENSITY 2
// timing counts in serial bits
`define RCS_DENSITY_LIMIT 6'h3c
`define RCS_BITS_PER_CHAR 4'ha
`define RCS_HALF_CHAR_BITS 4'h5
`endif

/* File: rcs_pkg.sv */
// types of the receive clock source selector
package rcs_pkg;
    // lock source of the recovery pll
    typedef enum logic {RCS_SRC_REF, RCS_SRC_DATA} rcs_src_t;
    // apb slave phase
    typedef enum logic [1:0] {RCS_IDLE, RCS_ACCESS, RCS_DONE} rcs_apb_t;
endpackage

/* File: rcs_serial_source.sv */
// stand-in for the recovered serial stream feeding the selector
`timescale 1ns/1ps
`default_nettype none
module rcs_serial_source (
    // clock
    input wire logic i_clk_sys,
    // stream control
    input wire logic i_stuck,
    // recovered bit lines
    output logic o_rx_bit,
    output logic o_bit_toggle
);
    logic [2:0] div; // five clocks a bit, under the clk/4 limit
    initial begin
        o_rx_bit = 1'b0;
        o_bit_toggle = 1'b0;
        div = 3'h0;
    end
    // bit value moves two clocks before its toggle, so it is stable
    always @(posedge i_clk_sys) begin
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        if (div == 3'h0 && !i_stuck) begin
            o_rx_bit <= ~o_rx_bit; // alternating bits, or a flat run when stuck
        end
        if (div == 3'h2) begin
            o_bit_toggle <= ~o_bit_toggle;
        end
    end
endmodule // rcs_serial_source
`default_nettype wire
